// ---- art_timers.sv ----
// timer three control plus toggle-output timers four and five
`timescale 1ns/1ps
module art_timers
  import art_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic ext_clk,
  input wire logic timer_irq_enable,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_page,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  output logic timer3_irq,
  output logic capture_mode,
  output logic toggle4_out,
  output logic toggle5_out,
  output logic toggle4_oe,
  output logic toggle5_oe
);
  // ==========================================
  // decode helper
  function automatic logic hit(input logic [7:0] pg, input logic [7:0] ad);
    hit = sfr_wr && (sfr_page == pg) && (sfr_addr == ad);
  endfunction : hit

  // ==========================================
  // timer clock ticks
  logic [3:0] sys_div_reg;
  logic sys_tick_reg;
  logic ext_s1_reg, ext_s2_reg, ext_s3_reg;
  logic [2:0] ext_div_reg;
  logic ext_tick_reg;
  always_ff @(posedge clk) begin
    if (srst) begin
      sys_div_reg <= 4'h0;
      sys_tick_reg <= 1'b0;
    end else begin
      sys_tick_reg <= (sys_div_reg == SYS_DIV);
      sys_div_reg <= (sys_div_reg == SYS_DIV) ? 4'h0 : sys_div_reg + 4'h1;
    end
  end
  // external clock brought in through two flops, divided by eight
  always_ff @(posedge clk) begin
    if (srst) begin
      ext_s1_reg <= 1'b0;
      ext_s2_reg <= 1'b0;
      ext_s3_reg <= 1'b0;
      ext_div_reg <= 3'h0;
      ext_tick_reg <= 1'b0;
    end else begin
      ext_s1_reg <= ext_clk;
      ext_s2_reg <= ext_s1_reg;
      ext_s3_reg <= ext_s2_reg;
      ext_tick_reg <= 1'b0;
      if (ext_s2_reg && !ext_s3_reg) begin
        ext_div_reg <= ext_div_reg + 3'h1;
        ext_tick_reg <= (ext_div_reg == EXT_DIV); // RULE_09
      end
    end
  end

  // ==========================================
  // timer three
  logic [7:0] t3_ctrl_reg, clk_ctrl_reg;
  logic [7:0] t3_low_reg, t3_high_reg, t3_rll_reg, t3_rlh_reg;
  logic t3_base_tick, t3_low_tick, t3_high_tick, t3_low_wrap, t3_high_wrap;
  logic t3_split, t3_run;
  assign t3_split = t3_ctrl_reg[B_SPLIT];
  assign t3_run = t3_ctrl_reg[B_RUN];
  assign t3_base_tick = t3_ctrl_reg[B_EXT_CLK] ? ext_tick_reg : sys_tick_reg; // RULE_09
  always_comb begin
    if (t3_split) begin
      // RULE_10
      t3_low_tick = clk_ctrl_reg[B_LOW_CLK] ? 1'b1 : t3_base_tick;
      t3_high_tick = clk_ctrl_reg[B_HIGH_CLK] ? 1'b1 : t3_base_tick;
      t3_high_tick = t3_high_tick && t3_run; // RULE_07
    end else begin
      t3_low_tick = t3_base_tick && t3_run; // RULE_07
      t3_high_tick = t3_low_tick && (t3_low_reg == BYTE_MAX); // RULE_06
    end
  end
  assign t3_low_wrap = t3_low_tick && (t3_low_reg == BYTE_MAX); // RULE_03
  assign t3_high_wrap = t3_high_tick && (t3_high_reg == BYTE_MAX); // RULE_01

  always_ff @(posedge clk) begin
    if (srst) begin
      t3_ctrl_reg <= RST_BYTE;
    end else begin
      if (hit(PAGE_T3, ADDR_T3_CTRL)) begin
        t3_ctrl_reg <= sfr_wdata & T3_CTRL_MASK; // RULE_08 RULE_19 RULE_05
      end
      if (t3_high_wrap) begin
        t3_ctrl_reg[B_HIGH_FLAG] <= 1'b1; // RULE_01
      end
      if (t3_low_wrap) begin
        t3_ctrl_reg[B_LOW_FLAG] <= 1'b1; // RULE_03
      end
    end
  end

  // ==========================================
  // timer three reload bytes and clock choices
  always_ff @(posedge clk) begin
    if (srst) begin
      clk_ctrl_reg <= RST_BYTE;
      t3_rll_reg <= RST_BYTE;
      t3_rlh_reg <= RST_BYTE;
    end else begin
      if (hit(PAGE_T3, ADDR_CLK_CTRL)) begin
        clk_ctrl_reg <= sfr_wdata; // RULE_10
      end
      if (hit(PAGE_T3, ADDR_T3_RLL)) begin
        t3_rll_reg <= sfr_wdata;
      end
      if (hit(PAGE_T3, ADDR_T3_RLH)) begin
        t3_rlh_reg <= sfr_wdata;
      end
    end
  end

  // ==========================================
  // timer three counter bytes: a byte write beats a same-cycle count
  always_ff @(posedge clk) begin
    if (srst) begin
      t3_low_reg <= RST_BYTE;
    end else if (hit(PAGE_T3, ADDR_T3_LOW)) begin
      t3_low_reg <= sfr_wdata;
    end else if (t3_low_wrap) begin
      t3_low_reg <= t3_rll_reg; // RULE_20
    end else if (t3_low_tick) begin
      t3_low_reg <= t3_low_reg + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      t3_high_reg <= RST_BYTE;
    end else if (hit(PAGE_T3, ADDR_T3_HIGH)) begin
      t3_high_reg <= sfr_wdata;
    end else if (t3_high_wrap) begin
      t3_high_reg <= t3_rlh_reg; // RULE_20
    end else if (t3_high_tick) begin
      t3_high_reg <= t3_high_reg + 8'h01;
    end
  end

  // ==========================================
  // interrupt request follows the flags
  always_ff @(posedge clk) begin
    if (srst) begin
      timer3_irq <= 1'b0;
      capture_mode <= 1'b0;
    end else begin
      timer3_irq <= timer_irq_enable && (t3_ctrl_reg[B_HIGH_FLAG] || // RULE_02
        (t3_ctrl_reg[B_LOW_FLAG] && t3_ctrl_reg[B_LOW_IRQ_EN])); // RULE_04
      capture_mode <= t3_ctrl_reg[B_CAP_EN]; // RULE_05
    end
  end

  // ==========================================
  // timers four and five, toggle output mode
  // wrap test shared by both toggle timers
  function automatic logic tt_wrap_hit(input logic [15:0] cnt, input logic [15:0] rl,
    input logic down);
    if (down) begin
      tt_wrap_hit = (cnt == rl); // RULE_12
    end else begin
      tt_wrap_hit = (cnt == WORD_MAX); // RULE_13
    end
  endfunction : tt_wrap_hit

  // next count on a tick: reload on wrap, else one step
  function automatic logic [15:0] tt_count(input logic [15:0] cnt, input logic [15:0] rl,
    input logic down, input logic wrap);
    if (wrap && down) begin
      tt_count = WORD_MAX; // RULE_12
    end else if (wrap) begin
      tt_count = rl; // RULE_13
    end else if (down) begin
      tt_count = cnt - 16'h0001;
    end else begin
      tt_count = cnt + 16'h0001; // RULE_20
    end
  endfunction : tt_count

  logic [7:0] t4_ctrl_reg, t4_cfg_reg, t5_ctrl_reg, t5_cfg_reg;
  logic [15:0] t4_cnt_reg, t4_rl_reg, t5_cnt_reg, t5_rl_reg;
  logic t4_tick, t4_down, t4_wrap, t5_tick, t5_down, t5_wrap;

  // ==========================================
  // timer four
  assign t4_tick = sys_tick_reg && t4_ctrl_reg[B_TT_RUN]; // RULE_15
  assign t4_down = t4_cfg_reg[B_TT_DOWN];
  assign t4_wrap = t4_tick && tt_wrap_hit(t4_cnt_reg, t4_rl_reg, t4_down); // RULE_11
  always_ff @(posedge clk) begin
    if (srst) begin
      t4_ctrl_reg <= RST_BYTE;
    end else if (hit(PAGE_T45, ADDR_TT_CTRL)) begin
      t4_ctrl_reg <= sfr_wdata; // RULE_15
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      t4_rl_reg <= {RST_BYTE, RST_BYTE};
    end else begin
      if (hit(PAGE_T45, ADDR_TT_RLL)) begin
        t4_rl_reg[7:0] <= sfr_wdata;
      end
      if (hit(PAGE_T45, ADDR_TT_RLH)) begin
        t4_rl_reg[15:8] <= sfr_wdata;
      end
    end
  end
  // a config write beats a same-cycle wrap so software can force the pin
  always_ff @(posedge clk) begin
    if (srst) begin
      t4_cfg_reg <= RST_BYTE;
    end else if (hit(PAGE_T45, ADDR_TT_CFG)) begin
      t4_cfg_reg <= sfr_wdata; // RULE_16
    end else if (t4_wrap) begin
      t4_cfg_reg[B_TT_STATE] <= ~t4_cfg_reg[B_TT_STATE]; // RULE_11
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      t4_cnt_reg <= {RST_BYTE, RST_BYTE};
    end else if (hit(PAGE_T45, ADDR_T4_LOW)) begin
      t4_cnt_reg[7:0] <= sfr_wdata; // RULE_18
    end else if (hit(PAGE_T45, ADDR_T4_HIGH)) begin
      t4_cnt_reg[15:8] <= sfr_wdata; // RULE_18
    end else if (t4_tick) begin
      t4_cnt_reg <= tt_count(t4_cnt_reg, t4_rl_reg, t4_down, t4_wrap); // RULE_20
    end
  end

  // ==========================================
  // timer five
  assign t5_tick = sys_tick_reg && t5_ctrl_reg[B_TT_RUN]; // RULE_15
  assign t5_down = t5_cfg_reg[B_TT_DOWN];
  assign t5_wrap = t5_tick && tt_wrap_hit(t5_cnt_reg, t5_rl_reg, t5_down); // RULE_11
  always_ff @(posedge clk) begin
    if (srst) begin
      t5_ctrl_reg <= RST_BYTE;
    end else if (hit(PAGE_T45, ADDR_T5_CTRL)) begin
      t5_ctrl_reg <= sfr_wdata; // RULE_15
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      t5_rl_reg <= {RST_BYTE, RST_BYTE};
    end else begin
      if (hit(PAGE_T45, ADDR_T5_RLL)) begin
        t5_rl_reg[7:0] <= sfr_wdata;
      end
      if (hit(PAGE_T45, ADDR_T5_RLH)) begin
        t5_rl_reg[15:8] <= sfr_wdata;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      t5_cfg_reg <= RST_BYTE;
    end else if (hit(PAGE_T45, ADDR_T5_CFG)) begin
      t5_cfg_reg <= sfr_wdata; // RULE_16
    end else if (t5_wrap) begin
      t5_cfg_reg[B_TT_STATE] <= ~t5_cfg_reg[B_TT_STATE]; // RULE_11
    end
  end
  always_ff @(posedge clk) begin
    if (srst) begin
      t5_cnt_reg <= {RST_BYTE, RST_BYTE};
    end else if (hit(PAGE_T45, ADDR_T5_LOW)) begin
      t5_cnt_reg[7:0] <= sfr_wdata; // RULE_18
    end else if (hit(PAGE_T45, ADDR_T5_HIGH)) begin
      t5_cnt_reg[15:8] <= sfr_wdata; // RULE_18
    end else if (t5_tick) begin
      t5_cnt_reg <= tt_count(t5_cnt_reg, t5_rl_reg, t5_down, t5_wrap); // RULE_20
    end
  end

  // ==========================================
  // toggle pins
  always_ff @(posedge clk) begin
    if (srst) begin
      toggle4_out <= 1'b0;
      toggle5_out <= 1'b0;
      toggle4_oe <= 1'b0;
      toggle5_oe <= 1'b0;
    end else begin
      toggle4_out <= t4_cfg_reg[B_TT_STATE]; // RULE_11
      toggle5_out <= t5_cfg_reg[B_TT_STATE]; // RULE_11
      toggle4_oe <= t4_cfg_reg[B_TT_OE];
      toggle5_oe <= t5_cfg_reg[B_TT_OE];
    end
  end

  // ==========================================
  // read data, registered
  logic [7:0] rdata_next;
  always_comb begin
    rdata_next = RST_BYTE;
    if (sfr_page == PAGE_T3) begin
      case (sfr_addr)
        ADDR_T3_CTRL: rdata_next = t3_ctrl_reg; // RULE_08
        ADDR_CLK_CTRL: rdata_next = clk_ctrl_reg;
        ADDR_T3_RLL: rdata_next = t3_rll_reg;
        ADDR_T3_RLH: rdata_next = t3_rlh_reg;
        ADDR_T3_LOW: rdata_next = t3_low_reg;
        ADDR_T3_HIGH: rdata_next = t3_high_reg;
        default: rdata_next = RST_BYTE;
      endcase
    end else if (sfr_page == PAGE_T45) begin
      case (sfr_addr)
        ADDR_T4_LOW: rdata_next = t4_cnt_reg[7:0]; // RULE_18
        ADDR_T4_HIGH: rdata_next = t4_cnt_reg[15:8];
        ADDR_T5_LOW: rdata_next = t5_cnt_reg[7:0];
        ADDR_T5_HIGH: rdata_next = t5_cnt_reg[15:8];
        ADDR_TT_CTRL: rdata_next = t4_ctrl_reg;
        ADDR_TT_CFG: rdata_next = t4_cfg_reg; // RULE_16
        ADDR_TT_RLL: rdata_next = t4_rl_reg[7:0];
        ADDR_TT_RLH: rdata_next = t4_rl_reg[15:8];
        ADDR_T5_CTRL: rdata_next = t5_ctrl_reg;
        ADDR_T5_CFG: rdata_next = t5_cfg_reg; // RULE_16
        ADDR_T5_RLL: rdata_next = t5_rl_reg[7:0];
        ADDR_T5_RLH: rdata_next = t5_rl_reg[15:8];
        default: rdata_next = RST_BYTE;
      endcase
    end
  end

  // read data holds until the next read strobe
  always_ff @(posedge clk) begin
    if (srst) begin
      sfr_rdata <= RST_BYTE;
    end else if (sfr_rd) begin
      sfr_rdata <= rdata_next;
    end
  end
endmodule : art_timers

// ---- art_pkg.sv ----
// constants and types for the auto-reload timers with toggle output
// Summary of operation
// RULE_01: high flag sets on upper byte wrap
// RULE_02: high flag raises interrupt when enabled
// RULE_03: low flag sets on every low wrap
// RULE_04: low wrap interrupts when low enable set
// RULE_05: capture bit enables or disables capture mode
// RULE_06: split bit picks 16-bit or two 8-bit
// RULE_07: run bit starts; split gates high only
// RULE_08: control bit one reads zero, ignores writes
// RULE_09: clock select: system_clock/12 or extclk/8 synchronized
// RULE_10: split uses per-byte clock choices too
// RULE_11: timers four/five toggle pin on wrap
// RULE_12: down count reloads 0xffff, underflow on match
// RULE_13: up count reloads capture value past 0xffff
// RULE_14: software clears select bits, sets output enable
// RULE_15: toggling starts when run bit set
// RULE_16: toggle state bit reads level, write forces
// RULE_17: software picks reload for wanted frequency
// RULE_18: byte registers hold halves or 8-bit values
// RULE_19: software writes set or clear flags
// RULE_20: counters increment per tick, reload without loss
package art_pkg;
  // ==========================================
  // register addresses
  localparam logic [7:0] ADDR_T3_CTRL = 8'h91;
  localparam logic [7:0] ADDR_T3_RLL = 8'h92;
  localparam logic [7:0] ADDR_T3_RLH = 8'h93;
  localparam logic [7:0] ADDR_T3_LOW = 8'h94;
  localparam logic [7:0] ADDR_T3_HIGH = 8'h95;
  localparam logic [7:0] ADDR_CLK_CTRL = 8'h8e;
  localparam logic [7:0] ADDR_T5_LOW = 8'h94;
  localparam logic [7:0] ADDR_T5_HIGH = 8'h95;
  localparam logic [7:0] ADDR_T4_LOW = 8'hcc;
  localparam logic [7:0] ADDR_T4_HIGH = 8'hcd;
  localparam logic [7:0] ADDR_TT_CTRL = 8'hc8;
  localparam logic [7:0] ADDR_TT_CFG = 8'hc9;
  localparam logic [7:0] ADDR_TT_RLL = 8'hca;
  localparam logic [7:0] ADDR_TT_RLH = 8'hcb;
  localparam logic [7:0] ADDR_T5_CTRL = 8'hd8;
  localparam logic [7:0] ADDR_T5_CFG = 8'hd9;
  localparam logic [7:0] ADDR_T5_RLL = 8'hda;
  localparam logic [7:0] ADDR_T5_RLH = 8'hdb;
  // register pages
  localparam logic [7:0] PAGE_T3 = 8'h00;
  localparam logic [7:0] PAGE_T45 = 8'h10;
  // ==========================================
  // timer three control fields
  localparam int B_HIGH_FLAG = 7;
  localparam int B_LOW_FLAG = 6;
  localparam int B_LOW_IRQ_EN = 5;
  localparam int B_CAP_EN = 4;
  localparam int B_SPLIT = 3;
  localparam int B_RUN = 2;
  localparam int B_EXT_CLK = 0;
  localparam logic [7:0] T3_CTRL_MASK = 8'hfd;
  // clock control fields
  localparam int B_HIGH_CLK = 7;
  localparam int B_LOW_CLK = 6;
  // toggle timer control and config fields
  localparam int B_TT_RUN = 2;
  localparam int B_TT_CAPSEL = 0;
  localparam int B_TT_CTSEL = 1;
  localparam int B_TT_DOWN = 3;
  localparam int B_TT_STATE = 2;
  localparam int B_TT_OE = 1;
  // ==========================================
  // reset values and timing
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] BYTE_MAX = 8'hff;
  localparam logic [15:0] WORD_MAX = 16'hffff;
  localparam logic [3:0] SYS_DIV = 4'hb;
  localparam logic [2:0] EXT_DIV = 3'h7;
  typedef enum {ART_IDLE, ART_RUN} art_state_t;
endpackage : art_pkg

// ---- art_timers_sva.sv ----
// assertions on the timer block ports
`timescale 1ns/1ps
module art_timers_chk
  import art_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic timer_irq_enable,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_page,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic timer3_irq,
  input wire logic capture_mode,
  input wire logic toggle4_oe,
  input wire logic toggle5_oe
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  logic wr_ctl, rd_ctl, wr_c4, wr_c5;
  assign wr_ctl = sfr_wr && sfr_page == PAGE_T3 && sfr_addr == ADDR_T3_CTRL;
  assign rd_ctl = sfr_rd && sfr_page == PAGE_T3 && sfr_addr == ADDR_T3_CTRL;
  assign wr_c4 = sfr_wr && sfr_page == PAGE_T45 && sfr_addr == ADDR_TT_CFG;
  assign wr_c5 = sfr_wr && sfr_page == PAGE_T45 && sfr_addr == 8'hd9;
  property p_cap; wr_ctl ##1 !wr_ctl |=> capture_mode == $past(sfr_wdata[B_CAP_EN], 2); endproperty
  a_cap: assert property (p_cap) else $error("capture mode not taken");
  property p_cap_hold; !wr_ctl ##1 !wr_ctl |=> $stable(capture_mode); endproperty
  a_cap_hold: assert property (p_cap_hold) else $error("capture mode moved");
  property p_bit1; rd_ctl |=> !sfr_rdata[1]; endproperty
  a_bit1: assert property (p_bit1) else $error("unused bit read high");
  property p_irq_off; !timer_irq_enable |=> !timer3_irq; endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq while disabled");
  property p_irq_sw; wr_ctl && sfr_wdata[B_HIGH_FLAG] && timer_irq_enable ##1 timer_irq_enable
    |=> timer3_irq; endproperty
  a_irq_sw: assert property (p_irq_sw) else $error("flag write gave no irq");
  property p_oe4; wr_c4 ##1 !wr_c4 |=> toggle4_oe == $past(sfr_wdata[B_TT_OE], 2); endproperty
  a_oe4: assert property (p_oe4) else $error("timer four enable wrong");
  property p_oe5; wr_c5 ##1 !wr_c5 |=> toggle5_oe == $past(sfr_wdata[B_TT_OE], 2); endproperty
  a_oe5: assert property (p_oe5) else $error("timer five enable wrong");
  property p_rd_hold; !sfr_rd |=> $stable(sfr_rdata); endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
endmodule : art_timers_chk

bind art_timers art_timers_chk art_timers_chk_i (.clk(clk), .srst(srst),
  .timer_irq_enable(timer_irq_enable), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_page(sfr_page),
  .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .timer3_irq(timer3_irq),
  .capture_mode(capture_mode), .toggle4_oe(toggle4_oe), .toggle5_oe(toggle5_oe));

// ---- tb_top.sv ----
// self-checking bench for the auto-reload timers
`timescale 1ns/1ps
module tb_top;
  import art_pkg::*;
  logic clk = 0, srst = 1, ext_clk = 0, timer_irq_enable = 0, sfr_wr = 0, sfr_rd = 0;
  logic [7:0] sfr_page = 0, sfr_addr = 0, sfr_wdata = 0, sfr_rdata, d;
  logic timer3_irq, capture_mode, toggle4_out, toggle5_out, toggle4_oe, toggle5_oe;
  int n_errors = 0, n_checks = 0, k;
  typedef struct {logic [7:0] pg, ad, wd, ex;} art_row_t;
  art_row_t rows [9] = '{'{PAGE_T45, ADDR_T4_LOW, 8'ha5, 8'ha5},
    '{PAGE_T45, ADDR_T4_HIGH, 8'h5a, 8'h5a}, '{PAGE_T45, ADDR_T5_LOW, 8'h3c, 8'h3c},
    '{PAGE_T45, ADDR_T5_HIGH, 8'hc3, 8'hc3}, '{PAGE_T3, ADDR_T3_CTRL, 8'h32, 8'h30},
    '{PAGE_T3, ADDR_T3_LOW, 8'h11, 8'h11}, '{PAGE_T45, ADDR_TT_CFG, 8'h02, 8'h02},
    '{PAGE_T45, 8'hd9, 8'h02, 8'h02}, '{PAGE_T3, 8'h80, 8'hff, 8'h00}};
  always #10 clk = ~clk;
  // ===========================================
  // slow external clock, three system cycles per half period
  always begin
    repeat (3) @(posedge clk);
    ext_clk <= ~ext_clk;
  end
  art_timers art_timers_i (.clk(clk), .srst(srst), .ext_clk(ext_clk),
    .timer_irq_enable(timer_irq_enable), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_page(sfr_page), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .timer3_irq(timer3_irq), .capture_mode(capture_mode), .toggle4_out(toggle4_out),
    .toggle5_out(toggle5_out), .toggle4_oe(toggle4_oe), .toggle5_oe(toggle5_oe));
  // ===========================================
  // bus tasks and comparison
  task automatic wr(input logic [7:0] pg, input logic [7:0] ad, input logic [7:0] wd);
    @(posedge clk);
    sfr_wr <= 1;
    sfr_page <= pg;
    sfr_addr <= ad;
    sfr_wdata <= wd;
    @(posedge clk);
    sfr_wr <= 0;
  endtask : wr
  task automatic rd(input logic [7:0] pg, input logic [7:0] ad, output logic [7:0] q);
    @(posedge clk);
    sfr_rd <= 1;
    sfr_page <= pg;
    sfr_addr <= ad;
    @(posedge clk);
    sfr_rd <= 0;
    #1 q = sfr_rdata;
  endtask : rd
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic final_report;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : final_report
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    final_report();
  end
  // ===========================================
  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    srst <= 0;
    foreach (rows[i]) begin
      wr(rows[i].pg, rows[i].ad, rows[i].wd);
      rd(rows[i].pg, rows[i].ad, d);
      chk(d, rows[i].ex);
    end
    rd(PAGE_T45, ADDR_T5_LOW, d);
    chk(d, 8'h3c);
    @(posedge clk);
    srst <= 1;
    repeat (2) @(posedge clk);
    srst <= 0;
    for (k = 0; k < 5; k++) begin
      rd(rows[k].pg, rows[k].ad, d);
      chk(d, 8'h00);
    end
    chk({7'h0, capture_mode}, 8'h00);
    // toggle timer four, up count with reload 0xff00
    wr(PAGE_T45, ADDR_TT_RLH, 8'hff);
    wr(PAGE_T45, ADDR_T4_LOW, 8'hfe);
    wr(PAGE_T45, ADDR_T4_HIGH, 8'hff);
    wr(PAGE_T45, ADDR_TT_CFG, 8'h02);
    wr(PAGE_T45, ADDR_TT_CTRL, 8'h04);
    for (k = 0; k < 60 && toggle4_out !== 1'b1; k++) @(negedge clk);
    rd(PAGE_T45, ADDR_TT_CFG, d);
    chk(d, 8'h06);
    for (k = 0; k < 4000 && toggle4_out === 1'b1; k++) @(negedge clk);
    for (k = 0; k < 4000 && toggle4_out !== 1'b1; k++) @(negedge clk);
    chk(k[7:0], 8'h00);
    chk(k[15:8], 8'h0c);
    wr(PAGE_T45, ADDR_TT_CFG, 8'h02);
    repeat (2) @(posedge clk);
    chk({7'h0, toggle4_out}, 8'h00);
    // toggle timer five, down count matching 0xfff0: 16 ticks per half period
    wr(PAGE_T45, ADDR_T5_RLL, 8'hf0);
    wr(PAGE_T45, ADDR_T5_RLH, 8'hff);
    wr(PAGE_T45, ADDR_T5_LOW, 8'hff);
    wr(PAGE_T45, ADDR_T5_HIGH, 8'hff);
    wr(PAGE_T45, ADDR_T5_CFG, 8'h0a);
    wr(PAGE_T45, ADDR_T5_CTRL, 8'h04);
    for (k = 0; k < 400 && toggle5_out !== 1'b1; k++) @(negedge clk);
    for (k = 0; k < 400 && toggle5_out === 1'b1; k++) @(negedge clk);
    chk(k[7:0], 8'hc0);
    chk(k[15:8], 8'h00);
    // timer three 16-bit wrap and interrupt
    timer_irq_enable <= 1;
    wr(PAGE_T3, ADDR_T3_LOW, 8'hfe);
    wr(PAGE_T3, ADDR_T3_HIGH, 8'hff);
    wr(PAGE_T3, ADDR_T3_CTRL, 8'h04);
    repeat (40) @(posedge clk);
    rd(PAGE_T3, ADDR_T3_CTRL, d);
    chk(d, 8'hc4);
    chk({7'h0, timer3_irq}, 8'h01);
    wr(PAGE_T3, ADDR_T3_CTRL, 8'h00);
    repeat (3) @(posedge clk);
    chk({7'h0, timer3_irq}, 8'h00);
    wr(PAGE_T3, ADDR_T3_CTRL, 8'h80);
    wr(PAGE_T3, ADDR_T3_CTRL, 8'h00);
    // split mode, high byte stopped, low byte interrupt
    wr(PAGE_T3, ADDR_T3_LOW, 8'hfe);
    wr(PAGE_T3, ADDR_T3_HIGH, 8'h10);
    wr(PAGE_T3, ADDR_T3_CTRL, 8'h28);
    repeat (40) @(posedge clk);
    rd(PAGE_T3, ADDR_T3_HIGH, d);
    chk(d, 8'h10);
    rd(PAGE_T3, ADDR_T3_CTRL, d);
    chk(d, 8'h68);
    chk({7'h0, timer3_irq}, 8'h01);
    // 16-bit mode on the external clock: one tick every 48 cycles here
    wr(PAGE_T3, ADDR_T3_CTRL, 8'h05);
    wr(PAGE_T3, ADDR_T3_LOW, 8'hfe);
    repeat (30) @(posedge clk);
    rd(PAGE_T3, ADDR_T3_CTRL, d);
    chk(d, 8'h05);
    repeat (150) @(posedge clk);
    rd(PAGE_T3, ADDR_T3_CTRL, d);
    chk(d, 8'h45);
    final_report();
  end
endmodule : tb_top
